/* File: spf_params.svh */
// constants for the shared pin function select block
`ifndef SPF_PARAMS_SVH
`define SPF_PARAMS_SVH

// ****************************************
// pin numbering and widths
// ****************************************
`define SPF_NUM_PINS 26
`define SPF_ADDR_W 8
`define SPF_DATA_W 32
`define SPF_PA_BASE 0
`define SPF_PB_BASE 8
`define SPF_PD_BASE 16
`define SPF_PE_BASE 18

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define SPF_ADDR_FSEL_E 8'h00
`define SPF_ADDR_FSEL_A 8'h04
`define SPF_ADDR_FSEL_B 8'h08
`define SPF_ADDR_FSEL_D 8'h0C
`define SPF_ADDR_GPIO_OUT 8'h10
`define SPF_ADDR_GPIO_DIR 8'h14
`define SPF_ADDR_PIN_LEVEL 8'h18

// ****************************************
// reset values of selectors, gpio registers and read data
// ****************************************
`define SPF_FSEL_RST 16'h0000
`define SPF_FSEL_D_RST 4'h0
`define SPF_GPIO_RST 26'h000_0000
`define SPF_RDATA_RST 32'h0000_0000

`endif

/* File: spf_pkg.sv */
// types for the shared pin function select block
`include "spf_params.svh"

package spf_pkg;

  // two-bit function code of one pin
  typedef enum logic [1:0] {
    SPF_FUNC_GPIO = 2'b00,
    SPF_FUNC_ALT1 = 2'b01,
    SPF_FUNC_ALT2 = 2'b10,
    SPF_FUNC_RSVD = 2'b11
  } spf_func_t;

  // complete state of the mux top
  typedef struct packed {
    logic [15:0] fsel_e;
    logic [15:0] fsel_a;
    logic [15:0] fsel_b;
    logic [3:0] fsel_d;
    logic [`SPF_NUM_PINS-1:0] gpio_out;
    logic [`SPF_NUM_PINS-1:0] gpio_dir;
    logic [`SPF_DATA_W-1:0] rdata;
    logic [`SPF_NUM_PINS-1:0] pin_out;
    logic [`SPF_NUM_PINS-1:0] pin_oe;
    logic uart_main_rx;
    logic uart_light_rx;
    logic spi_miso;
    logic i2c_scl_in;
    logic i2c_sda_in;
    logic cts_n;
    logic card_wait_n;
    logic card_irq;
    logic card_stschg_n;
    logic [8:0] ext_int;
    logic [2:0] audio0_in;
    logic [2:0] audio1_in;
  } spf_state_t;

endpackage : spf_pkg

/* File: spf_pin_sync.sv */
// three-stage pin input synchroniser with agreement filter
`timescale 1ns/100ps
`include "spf_params.svh"

module spf_pin_sync #(
  parameter int WIDTH = `SPF_NUM_PINS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_level
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } spf_sync_state_t;

  spf_sync_state_t state_reg;
  spf_sync_state_t state_next;

  // *****************************
  // next state per bit
  // *****************************
  // s1 feeds only s2; a level change counts once s2 and s3 agree
  always_comb
  begin
    state_next = state_reg;
    state_next.s1 = pin_async;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (state_reg.s2[i] == state_reg.s3[i])
      begin
        state_next.level[i] = state_reg.s3[i];
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign pin_level = state_reg.level;

endmodule : spf_pin_sync

/* File: spf_pin_mux.sv */
// pin function multiplexer for ports a, b, d (pins 0-1) and e
// Notes on behaviour
// RULE1: e0 field 1:0, card read strobe, audio0 data
// RULE2: e1 field 3:2, card write strobe, audio0 clock
// RULE3: e2 field 5:4, card wait, memctl wait
// RULE4: e3 field 7:6, card reset, audio0 word select
// RULE5: card reset pin high while card reset
// RULE6: e4 field 9:8, card interrupt request in
// RULE7: e5 field 11:10, status change, audio1 data
// RULE8: e6 field 13:12, buffer enable, audio1 clock
// RULE9: e7 field 15:14, data direction, audio1 word select
// RULE10: direction pin low during card data reads
// RULE11: all pins gpio inputs after reset
// RULE12: a0/a1 main uart transmit and receive
// RULE13: a2-a5 spi; a2/a3 light uart alternate
// RULE14: a6/a7 bidirectional i2c clock and data
// RULE15: b1/b2 rts, cts; alternate audio0 clock, data
// RULE16: b3-b5 timer outputs; b3 audio1 data
// RULE17: b6,b7,d0,d1 address 22,23,20,21; audio1 alternates
// RULE18: b0 alternate is audio0 word select
// RULE19: code 00 gpio, 01 one, 10 two, 11 gpio
// RULE20: b0-b7 and d0 always feed interrupts 0-8
`timescale 1ns/100ps
`include "spf_params.svh"

module spf_pin_mux (
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [`SPF_ADDR_W-1:0] reg_addr,
  input wire logic [`SPF_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [`SPF_DATA_W-1:0] reg_rdata,
  // pads: a0..a7, b0..b7, d0, d1, e0..e7
  input wire logic [`SPF_NUM_PINS-1:0] pin_in,
  output logic [`SPF_NUM_PINS-1:0] pin_out,
  output logic [`SPF_NUM_PINS-1:0] pin_oe,
  // card controller side
  input wire logic card_io_read_strobe_n,
  input wire logic card_io_write_strobe_n,
  input wire logic card_in_reset,
  input wire logic card_buffer_enable_n,
  input wire logic card_data_read,
  output logic card_wait_request_n,
  output logic memctl_wait_in_n,
  output logic card_irq_in,
  output logic card_status_change_n,
  // uart, spi, i2c, timers, address
  input wire logic uart_main_tx,
  output logic uart_main_rx,
  input wire logic uart_main_request_to_send_n,
  output logic uart_main_clear_to_send_n,
  input wire logic uart_light_tx,
  output logic uart_light_rx,
  input wire logic spi_select_n,
  input wire logic spi_clock,
  input wire logic spi_mosi,
  output logic spi_miso,
  input wire logic i2c_scl_drive_low,
  input wire logic i2c_sda_drive_low,
  output logic i2c_scl_in,
  output logic i2c_sda_in,
  input wire logic [2:0] timer_out,
  input wire logic ext_address_bit_20,
  input wire logic ext_address_bit_21,
  input wire logic ext_address_bit_22,
  input wire logic ext_address_bit_23,
  // audio: bit 0 data, bit 1 bit clock, bit 2 word select
  input wire logic [2:0] audio0_out,
  input wire logic [2:0] audio0_oe,
  output logic [2:0] audio0_in,
  input wire logic [2:0] audio1_out,
  input wire logic [2:0] audio1_oe,
  output logic [2:0] audio1_in,
  // external interrupt lines 0..8
  output logic [8:0] ext_interrupt_line
);

  localparam int PA = `SPF_PA_BASE;
  localparam int PB = `SPF_PB_BASE;
  localparam int PD = `SPF_PD_BASE;
  localparam int PE = `SPF_PE_BASE;

  spf_pkg::spf_state_t state_reg;
  spf_pkg::spf_state_t state_next;

  logic [`SPF_NUM_PINS-1:0] pin_level;
  logic [2*`SPF_NUM_PINS-1:0] fsel_all;
  logic [`SPF_NUM_PINS-1:0] alt1_out;
  logic [`SPF_NUM_PINS-1:0] alt1_oe;
  logic [`SPF_NUM_PINS-1:0] alt2_out;
  logic [`SPF_NUM_PINS-1:0] alt2_oe;
  logic [`SPF_NUM_PINS-1:0] mux_out;
  logic [`SPF_NUM_PINS-1:0] mux_oe;
  logic [`SPF_NUM_PINS-1:0] is_alt1;
  logic [`SPF_NUM_PINS-1:0] is_alt2;

  // ****************************************
  // pad input synchronisation
  // ****************************************
  spf_pin_sync #(
    .WIDTH(`SPF_NUM_PINS)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_async(pin_in),
    .pin_level(pin_level)
  );

  // one two-bit field per pin, in pin order
  assign fsel_all = {state_reg.fsel_e, state_reg.fsel_d, state_reg.fsel_b, state_reg.fsel_a};

  // ****************************************
  // alternate function tables
  // ****************************************
  // unused slots stay undriven inputs
  always_comb
  begin
    alt1_out = '0;
    alt1_oe = '0;
    alt2_out = '0;
    alt2_oe = '0;
    // RULE12: main uart transmit
    alt1_out[PA + 0] = uart_main_tx;
    alt1_oe[PA + 0] = 1'b1;
    // RULE13: spi master outputs, light uart transmit
    alt1_out[PA + 2] = spi_select_n;
    alt1_oe[PA + 2] = 1'b1;
    alt1_out[PA + 3] = spi_clock;
    alt1_oe[PA + 3] = 1'b1;
    alt1_out[PA + 5] = spi_mosi;
    alt1_oe[PA + 5] = 1'b1;
    alt2_out[PA + 2] = uart_light_tx;
    alt2_oe[PA + 2] = 1'b1;
    // RULE14: i2c open drain, only ever pulls low
    alt1_oe[PA + 6] = i2c_scl_drive_low;
    alt1_oe[PA + 7] = i2c_sda_drive_low;
    // RULE18: audio0 word select on b0
    alt2_out[PB + 0] = audio0_out[2];
    alt2_oe[PB + 0] = audio0_oe[2];
    // RULE15: rts out, audio0 clock and data
    alt1_out[PB + 1] = uart_main_request_to_send_n;
    alt1_oe[PB + 1] = 1'b1;
    alt2_out[PB + 1] = audio0_out[1];
    alt2_oe[PB + 1] = audio0_oe[1];
    alt2_out[PB + 2] = audio0_out[0];
    alt2_oe[PB + 2] = audio0_oe[0];
    // RULE16: timer outputs, audio1 data on b3
    for (int t = 0; t < 3; t++)
    begin
      alt1_out[PB + 3 + t] = timer_out[t];
      alt1_oe[PB + 3 + t] = 1'b1;
    end
    alt2_out[PB + 3] = audio1_out[0];
    alt2_oe[PB + 3] = audio1_oe[0];
    // RULE17: upper address bits, audio1 clock and word select
    alt1_out[PB + 6] = ext_address_bit_22;
    alt1_out[PB + 7] = ext_address_bit_23;
    alt1_out[PD + 0] = ext_address_bit_20;
    alt1_out[PD + 1] = ext_address_bit_21;
    alt1_oe[PB + 6] = 1'b1;
    alt1_oe[PB + 7] = 1'b1;
    alt1_oe[PD + 0] = 1'b1;
    alt1_oe[PD + 1] = 1'b1;
    alt2_out[PB + 6] = audio1_out[1];
    alt2_oe[PB + 6] = audio1_oe[1];
    alt2_out[PB + 7] = audio1_out[2];
    alt2_oe[PB + 7] = audio1_oe[2];
    // RULE1: card read strobe, audio0 data
    alt1_out[PE + 0] = card_io_read_strobe_n;
    alt1_oe[PE + 0] = 1'b1;
    alt2_out[PE + 0] = audio0_out[0];
    alt2_oe[PE + 0] = audio0_oe[0];
    // RULE2: card write strobe, audio0 clock
    alt1_out[PE + 1] = card_io_write_strobe_n;
    alt1_oe[PE + 1] = 1'b1;
    alt2_out[PE + 1] = audio0_out[1];
    alt2_oe[PE + 1] = audio0_oe[1];
    // RULE4: card reset, audio0 word select
    // RULE5: high while the card is held in reset
    alt1_out[PE + 3] = card_in_reset;
    alt1_oe[PE + 3] = 1'b1;
    alt2_out[PE + 3] = audio0_out[2];
    alt2_oe[PE + 3] = audio0_oe[2];
    // RULE7: audio1 data alternate on e5
    alt2_out[PE + 5] = audio1_out[0];
    alt2_oe[PE + 5] = audio1_oe[0];
    // RULE8: buffer enable, audio1 clock
    alt1_out[PE + 6] = card_buffer_enable_n;
    alt1_oe[PE + 6] = 1'b1;
    alt2_out[PE + 6] = audio1_out[1];
    alt2_oe[PE + 6] = audio1_oe[1];
    // RULE9: direction indicator, audio1 word select
    // RULE10: low during card data reads
    alt1_out[PE + 7] = ~card_data_read;
    alt1_oe[PE + 7] = 1'b1;
    alt2_out[PE + 7] = audio1_out[2];
    alt2_oe[PE + 7] = audio1_oe[2];
  end

  // ****************************************
  // per pin function select
  // ****************************************
  genvar p;
  generate
    for (p = 0; p < `SPF_NUM_PINS; p++)
    begin : g_pin
      // RULE19: reserved code 11 falls back to gpio
      assign is_alt1[p] = (fsel_all[2*p+1:2*p] == spf_pkg::SPF_FUNC_ALT1);
      assign is_alt2[p] = (fsel_all[2*p+1:2*p] == spf_pkg::SPF_FUNC_ALT2);
      assign mux_out[p] = is_alt1[p] ? alt1_out[p] :
                          (is_alt2[p] ? alt2_out[p] : state_reg.gpio_out[p]);
      assign mux_oe[p] = is_alt1[p] ? alt1_oe[p] :
                         (is_alt2[p] ? alt2_oe[p] : state_reg.gpio_dir[p]);
    end
  endgenerate

  // ****************************************
  // next state: registers, pads, inputs
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    state_next.pin_out = mux_out;
    state_next.pin_oe = mux_oe;
    // peripheral inputs idle at inactive levels when not routed
    state_next.uart_main_rx = is_alt1[PA + 1] ? pin_level[PA + 1] : 1'b1;
    state_next.uart_light_rx = is_alt2[PA + 3] ? pin_level[PA + 3] : 1'b1;
    state_next.spi_miso = is_alt1[PA + 4] ? pin_level[PA + 4] : 1'b0;
    state_next.i2c_scl_in = is_alt1[PA + 6] ? pin_level[PA + 6] : 1'b1;
    state_next.i2c_sda_in = is_alt1[PA + 7] ? pin_level[PA + 7] : 1'b1;
    state_next.cts_n = is_alt1[PB + 2] ? pin_level[PB + 2] : 1'b1;
    // RULE3: one pin serves card wait and memctl wait
    state_next.card_wait_n = is_alt1[PE + 2] ? pin_level[PE + 2] : 1'b1;
    // RULE6: card interrupt request routed in
    state_next.card_irq = is_alt1[PE + 4] ? pin_level[PE + 4] : 1'b0;
    // RULE7: card status change routed in
    state_next.card_stschg_n = is_alt1[PE + 5] ? pin_level[PE + 5] : 1'b1;
    // RULE20: interrupt lines follow pads regardless of function
    state_next.ext_int = {pin_level[PD + 0], pin_level[PB +: 8]};
    // port e choice wins over port b when both route audio
    state_next.audio0_in[0] = is_alt2[PE + 0] ? pin_level[PE + 0] :
                              (is_alt2[PB + 2] ? pin_level[PB + 2] : 1'b0);
    state_next.audio0_in[1] = is_alt2[PE + 1] ? pin_level[PE + 1] :
                              (is_alt2[PB + 1] ? pin_level[PB + 1] : 1'b0);
    state_next.audio0_in[2] = is_alt2[PE + 3] ? pin_level[PE + 3] :
                              (is_alt2[PB + 0] ? pin_level[PB + 0] : 1'b0);
    state_next.audio1_in[0] = is_alt2[PE + 5] ? pin_level[PE + 5] :
                              (is_alt2[PB + 3] ? pin_level[PB + 3] : 1'b0);
    state_next.audio1_in[1] = is_alt2[PE + 6] ? pin_level[PE + 6] :
                              (is_alt2[PB + 6] ? pin_level[PB + 6] : 1'b0);
    state_next.audio1_in[2] = is_alt2[PE + 7] ? pin_level[PE + 7] :
                              (is_alt2[PB + 7] ? pin_level[PB + 7] : 1'b0);
    // register writes
    if (reg_write)
    begin
      unique case (reg_addr)
        `SPF_ADDR_FSEL_E: state_next.fsel_e = reg_wdata[15:0];
        `SPF_ADDR_FSEL_A: state_next.fsel_a = reg_wdata[15:0];
        `SPF_ADDR_FSEL_B: state_next.fsel_b = reg_wdata[15:0];
        `SPF_ADDR_FSEL_D: state_next.fsel_d = reg_wdata[3:0];
        `SPF_ADDR_GPIO_OUT: state_next.gpio_out = reg_wdata[`SPF_NUM_PINS-1:0];
        `SPF_ADDR_GPIO_DIR: state_next.gpio_dir = reg_wdata[`SPF_NUM_PINS-1:0];
        default: ;
      endcase
    end
    // read data stand one cycle only, zero otherwise and when unmapped
    state_next.rdata = `SPF_RDATA_RST;
    if (reg_read)
    begin
      unique case (reg_addr)
        `SPF_ADDR_FSEL_E: state_next.rdata = {16'h0000, state_reg.fsel_e};
        `SPF_ADDR_FSEL_A: state_next.rdata = {16'h0000, state_reg.fsel_a};
        `SPF_ADDR_FSEL_B: state_next.rdata = {16'h0000, state_reg.fsel_b};
        `SPF_ADDR_FSEL_D: state_next.rdata = {28'h000_0000, state_reg.fsel_d};
        `SPF_ADDR_GPIO_OUT: state_next.rdata = {6'h00, state_reg.gpio_out};
        `SPF_ADDR_GPIO_DIR: state_next.rdata = {6'h00, state_reg.gpio_dir};
        `SPF_ADDR_PIN_LEVEL: state_next.rdata = {6'h00, pin_level};
        default: state_next.rdata = `SPF_RDATA_RST;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // RULE11: reset leaves every pin a gpio input
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
      state_reg.fsel_e <= `SPF_FSEL_RST;
      state_reg.fsel_a <= `SPF_FSEL_RST;
      state_reg.fsel_b <= `SPF_FSEL_RST;
      state_reg.fsel_d <= `SPF_FSEL_D_RST;
      state_reg.gpio_out <= `SPF_GPIO_RST;
      state_reg.gpio_dir <= `SPF_GPIO_RST;
      state_reg.uart_main_rx <= 1'b1;
      state_reg.uart_light_rx <= 1'b1;
      state_reg.i2c_scl_in <= 1'b1;
      state_reg.i2c_sda_in <= 1'b1;
      state_reg.cts_n <= 1'b1;
      state_reg.card_wait_n <= 1'b1;
      state_reg.card_stschg_n <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // outputs from the state register
  // ****************************************
  assign reg_rdata = state_reg.rdata;
  assign pin_out = state_reg.pin_out;
  assign pin_oe = state_reg.pin_oe;
  assign card_wait_request_n = state_reg.card_wait_n;
  assign memctl_wait_in_n = state_reg.card_wait_n;
  assign card_irq_in = state_reg.card_irq;
  assign card_status_change_n = state_reg.card_stschg_n;
  assign uart_main_rx = state_reg.uart_main_rx;
  assign uart_main_clear_to_send_n = state_reg.cts_n;
  assign uart_light_rx = state_reg.uart_light_rx;
  assign spi_miso = state_reg.spi_miso;
  assign i2c_scl_in = state_reg.i2c_scl_in;
  assign i2c_sda_in = state_reg.i2c_sda_in;
  assign audio0_in = state_reg.audio0_in;
  assign audio1_in = state_reg.audio1_in;
  assign ext_interrupt_line = state_reg.ext_int;

endmodule : spf_pin_mux

/* File: spf_pin_mux_chk.sv */
// assertion checker for the shared pin function mux
`timescale 1ns/100ps
`include "spf_params.svh"

module spf_pin_mux_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`SPF_ADDR_W-1:0] reg_addr,
  input wire logic [`SPF_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [`SPF_DATA_W-1:0] reg_rdata,
  input wire logic [`SPF_NUM_PINS-1:0] pin_out,
  input wire logic [`SPF_NUM_PINS-1:0] pin_oe,
  input wire logic card_io_read_strobe_n,
  input wire logic card_io_write_strobe_n,
  input wire logic card_in_reset,
  input wire logic card_data_read,
  input wire logic card_wait_request_n,
  input wire logic memctl_wait_in_n,
  input wire logic [2:0] audio1_out,
  input wire logic [2:0] audio1_oe
);
  // ****************
  // shadow of port e selector and direction
  // ****************
  logic [15:0] fe_reg;
  logic [7:0] dir_e_reg;
  logic [7:0] e_gpio;
  logic [7:0] e_drv;

  // follows bus writes, so no design internals are needed
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fe_reg <= 16'h0000;
      dir_e_reg <= 8'h00;
    end
    else if (reg_write && reg_addr == `SPF_ADDR_FSEL_E)
      fe_reg <= reg_wdata[15:0];
    else if (reg_write && reg_addr == `SPF_ADDR_GPIO_DIR)
      dir_e_reg <= reg_wdata[25:18];
  end

  // codes 00 and 11 both mean plain gpio
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      e_gpio[i] = fe_reg[2 * i] == fe_reg[2 * i + 1];
    e_drv = e_gpio & dir_e_reg;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ****************
  // pin function properties
  // ****************
  // read strobe pin
  property p_e0_rd;
    $past(fe_reg[1:0]) == 2'b01 |-> pin_oe[18] && pin_out[18] == $past(card_io_read_strobe_n);
  endproperty
  a_e0_rd: assert property (p_e0_rd) else $error("e0 read strobe wrong");
  property p_e1_wr;
    $past(fe_reg[3:2]) == 2'b01 |-> pin_oe[19] && pin_out[19] == $past(card_io_write_strobe_n);
  endproperty
  a_e1_wr: assert property (p_e1_wr) else $error("e1 write strobe wrong");
  property p_e3_rst;
    $past(fe_reg[7:6]) == 2'b01 |-> pin_oe[21] && pin_out[21] == $past(card_in_reset);
  endproperty
  a_e3_rst: assert property (p_e3_rst) else $error("e3 card reset wrong");
  property p_e7_dir;
    $past(fe_reg[15:14]) == 2'b01 |-> pin_oe[25] && pin_out[25] == !$past(card_data_read);
  endproperty
  a_e7_dir: assert property (p_e7_dir) else $error("e7 direction wrong");
  property p_e6_aud;
    $past(fe_reg[13:12]) == 2'b10 |-> pin_oe[24] == $past(audio1_oe[1]) &&
      pin_out[24] == $past(audio1_out[1]);
  endproperty
  a_e6_aud: assert property (p_e6_aud) else $error("e6 audio clock wrong");
  property p_wait_same;
    card_wait_request_n == memctl_wait_in_n;
  endproperty
  a_wait_same: assert property (p_wait_same) else $error("wait outputs differ");
  property p_wait_idle;
    $past(fe_reg[5:4]) != 2'b01 |-> card_wait_request_n;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("wait not idle");
  property p_e_gpio;
    ((pin_oe[25:18] ^ $past(e_drv)) & $past(e_gpio)) == 8'h00;
  endproperty
  a_e_gpio: assert property (p_e_gpio) else $error("gpio enable wrong");
  property p_rd_fsel;
    $past(reg_read) && $past(reg_addr) == `SPF_ADDR_FSEL_E |->
      reg_rdata == {16'h0000, $past(fe_reg)};
  endproperty
  a_rd_fsel: assert property (p_rd_fsel) else $error("selector read wrong");
endmodule : spf_pin_mux_chk

/* File: spf_pad_model.sv */
// pad model of the parts wired to the mux pins
`timescale 1ns/100ps
`include "spf_params.svh"

module spf_pad_model (
  input wire logic clk,
  input wire logic [`SPF_NUM_PINS-1:0] pin_out,
  input wire logic [`SPF_NUM_PINS-1:0] pin_oe,
  input wire logic [`SPF_NUM_PINS-1:0] ext_val,
  input wire logic [`SPF_NUM_PINS-1:0] ext_en,
  output logic [`SPF_NUM_PINS-1:0] pin_in
);
  // ****************
  // wire resolution
  // ****************
  logic wobble;

  // floating pads must not hold a tidy value
  initial wobble = 1'b0;
  always @(posedge clk)
    wobble <= ~wobble;

  // port e has pull-ups, the others float
  always_comb
  begin
    for (int i = 0; i < `SPF_NUM_PINS; i++)
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else
        pin_in[i] = (i >= `SPF_PE_BASE) ? 1'b1 : wobble;
  end
endmodule : spf_pad_model

/* File: spf_pin_mux_tb.sv */
// self-checking bench for the shared pin function mux
`timescale 1ns/100ps
`include "spf_params.svh"

module spf_pin_mux_tb;
  logic clk, rst_n, reg_write, reg_read, rd_pend;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, s, r, go, gd, q[$];
  logic [25:0] pin_in, pin_out, pin_oe, ext_val, ext_en, eo, ev, mo, lvl;
  logic [8:0] ext_int;
  logic [2:0] a0_in, a1_in;
  logic wait_n, memctl_wait_in_n_n, irq, stschg_n, mrx, cts_n, lrx, miso, scl_in, sda_in;
  int n_fail, samples_checked, seed;

  spf_pin_mux uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .card_io_read_strobe_n(s[0]),
    .card_io_write_strobe_n(s[1]), .card_in_reset(s[2]), .card_buffer_enable_n(s[3]),
    .card_data_read(s[4]), .card_wait_request_n(wait_n), .memctl_wait_in_n(memctl_wait_in_n_n),
    .card_irq_in(irq), .card_status_change_n(stschg_n), .uart_main_tx(s[5]),
    .uart_main_rx(mrx), .uart_main_request_to_send_n(s[6]),
    .uart_main_clear_to_send_n(cts_n), .uart_light_tx(s[7]), .uart_light_rx(lrx),
    .spi_select_n(s[8]), .spi_clock(s[9]), .spi_mosi(s[10]), .spi_miso(miso),
    .i2c_scl_drive_low(s[11]), .i2c_sda_drive_low(s[12]), .i2c_scl_in(scl_in),
    .i2c_sda_in(sda_in), .timer_out(s[15:13]), .ext_address_bit_20(s[16]),
    .ext_address_bit_21(s[17]), .ext_address_bit_22(s[18]), .ext_address_bit_23(s[19]),
    .audio0_out(s[22:20]), .audio0_oe(s[25:23]), .audio0_in(a0_in),
    .audio1_out(s[28:26]), .audio1_oe(s[31:29]), .audio1_in(a1_in),
    .ext_interrupt_line(ext_int));

  spf_pad_model u_pads (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
    .ext_en(ext_en), .pin_in(pin_in));

  // ****************
  // clock, tasks and monitor
  // ****************
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    q.push_back(e);
    @(posedge clk);
    reg_read <= 1'b0;
  endtask : rd

  // all selectors get one code; settle through the synchronisers
  task automatic setup(input logic [15:0] f, input logic [31:0] o, input logic [31:0] d);
    @(posedge clk);
    s <= $random(seed);
    ext_val <= 26'($random(seed));
    wr(`SPF_ADDR_FSEL_A, {16'h0000, f});
    wr(`SPF_ADDR_FSEL_B, {16'h0000, f});
    wr(`SPF_ADDR_FSEL_D, {28'h000_0000, f[3:0]});
    wr(`SPF_ADDR_FSEL_E, {16'h0000, f});
    wr(`SPF_ADDR_GPIO_OUT, o);
    wr(`SPF_ADDR_GPIO_DIR, d);
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask : setup

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  // read data stand only in the cycle after the strobe
  always @(posedge clk)
    rd_pend <= reg_read;
  always @(negedge clk)
    if (rd_pend)
      chk("read data", q.pop_front(), reg_rdata);

  // whole run is a few hundred cycles; this is far beyond it
  initial
  begin
    #100000;
    n_fail++;
    final_report();
  end

  // ****************
  // scenarios
  // ****************
  initial
  begin
    seed = 32'h0513_9915;
    rst_n = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    s = $random(seed);
    ext_val = 26'($random(seed));
    ext_en = 26'h003_FFFF;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("pin_oe", 32'h0000_0000, pin_oe);
    for (int i = 0; i < 6; i++)
      rd(8'(4 * i), 32'h0000_0000);
    rd(`SPF_ADDR_PIN_LEVEL, {6'h00, 8'hFF, ext_val[17:0]});
    $display("test reset done");
    ext_en <= 26'h3FF_FFFF;
    for (int i = 0; i < 6; i++)
    begin
      r = $random(seed);
      wr(8'(4 * i), r);
      rd(8'(4 * i), r & (i == 3 ? 32'h0000_000F : i < 3 ? 32'h0000_FFFF : 32'h03FF_FFFF));
    end
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0000_0000);
    $display("test registers done");
    for (int k = 0; k < 4; k++)
    begin
      setup(16'h5555, 32'h0000_0000, 32'h0000_0000);
      eo = {8'hCB, 2'b11, 8'hFA, s[12], s[11], 6'b10_1101};
      ev = {~s[4], s[3], 2'b00, s[2], 1'b0, s[1], s[0], s[17], s[16], s[19], s[18], s[15:13],
        1'b0, s[6], 3'b000, s[10], 1'b0, s[9], s[8], 1'b0, s[5]};
      mo = 26'h3FF_FEFF;
      lvl = (eo & ev) | (~eo & ext_val);
      chk("int lines", {lvl[16], lvl[15:8]}, ext_int);
      chk("pin_oe", eo & mo, pin_oe & mo);
      chk("pin_out", ev & eo & mo, pin_out & eo & mo);
      chk("serial in", {ext_val[1], ext_val[10], ext_val[4], ~s[11] & ext_val[6],
        ~s[12] & ext_val[7]}, {mrx, cts_n, miso, scl_in, sda_in});
      chk("card in", {ext_val[20], ext_val[20], ext_val[22], ext_val[23]},
        {wait_n, memctl_wait_in_n_n, irq, stschg_n});
    end
    $display("test function one done");
    for (int k = 0; k < 3; k++)
    begin
      setup(16'hAAAA, 32'h0000_0000, 32'h0000_0000);
      eo = {s[31:29], 1'b0, s[25], 1'b0, s[24], s[23], 2'b00, s[31], s[30], 2'b00, s[29],
        s[23], s[24], s[25], 8'h04};
      ev = {s[28:26], 1'b0, s[22], 1'b0, s[21], s[20], 2'b00, s[28], s[27], 2'b00, s[26],
        s[20], s[21], s[22], 5'h00, s[7], 2'b00};
      mo = {8'hEB, 2'b00, 8'hCF, 8'h0C};
      lvl = (eo & ev) | (~eo & ext_val);
      chk("pin_oe", eo & mo, pin_oe & mo);
      chk("pin_out", ev & eo & mo, pin_out & eo & mo);
      chk("light rx", ext_val[3], lrx);
      chk("audio in", {lvl[21], lvl[19], lvl[18], lvl[25:23]}, {a0_in, a1_in});
    end
    // port e back to gpio, so audio inputs fall back to port b
    wr(`SPF_ADDR_FSEL_E, 32'h0000_0000);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("audio in b", {lvl[8], lvl[9], lvl[10], lvl[15], lvl[14], lvl[11]},
      {a0_in, a1_in});
    $display("test function two done");
    for (int k = 0; k < 2; k++)
    begin
      go = $random(seed);
      gd = $random(seed);
      setup(k == 0 ? 16'hFFFF : 16'h0000, go, gd);
      lvl = (gd[25:0] & go[25:0]) | (~gd[25:0] & ext_val);
      chk("pin_oe", gd[25:0], pin_oe);
      chk("pin_out", go[25:0] & gd[25:0], pin_out & gd[25:0]);
      chk("int lines", {lvl[16], lvl[15:8]}, ext_int);
      chk("idle in", {9'b1_1110_1011, 6'h00}, {mrx, cts_n, lrx, wait_n, irq, stschg_n, miso,
        scl_in, sda_in, a0_in, a1_in});
      rd(`SPF_ADDR_PIN_LEVEL, {6'h00, lvl});
    end
    $display("test gpio done");
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule : spf_pin_mux_tb

bind spf_pin_mux spf_pin_mux_chk u_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .pin_out(pin_out), .pin_oe(pin_oe), .card_io_read_strobe_n(card_io_read_strobe_n),
  .card_io_write_strobe_n(card_io_write_strobe_n), .card_in_reset(card_in_reset),
  .card_data_read(card_data_read), .card_wait_request_n(card_wait_request_n),
  .memctl_wait_in_n(memctl_wait_in_n), .audio1_out(audio1_out), .audio1_oe(audio1_oe));
